// File: core/tid_core.sv
// timer and interrupt control instruction decoder with ahb-lite status port
//
// Summary of operation
// - one-byte reload write for timer 0 from memory nibble and accumulator, two cycles.
// - two-byte reload write for timer 1 register A from extension and accumulator.
// - one-byte read of timer 0 count into memory nibble and accumulator, two cycles.
// - two-byte read of timer 1 count into extension and accumulator.
// - two-byte instruction starts the timer 0 counter.
// - two-byte instruction starts the timer 1 counter.
// - two-byte instruction stops the timer 0 counter.
// - two-byte instruction stops the timer 1 counter.
// - two-byte instruction sets the master interrupt flag.
// - two-byte instruction clears the master interrupt flag.
// - immediate is ORed into the upper interrupt enable nibble.
// - immediate is ORed into the lower interrupt enable nibble.
// - upper enable nibble ANDed with inverted immediate, zero flag updated.
// - lower enable nibble ANDed with inverted immediate, zero flag updated.
`timescale 1ns/1ns
`default_nettype none
`include "tid_map.svh"

module tid_core
  import tid_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // instruction byte stream
  input  wire logic        INS_VALID,
  input  wire logic [7:0]  INS_BYTE,
  output logic             INS_READY,
  output logic             INS_DONE,
  // core operands and write-backs
  input  wire tid_cpu_in_t CPU_IN,
  output tid_cpu_wr_t      CPU_WR,
  // timers
  input  wire logic [7:0]  T0_COUNT,
  input  wire logic [7:0]  T1_COUNT,
  output logic      [7:0]  T0_RELOAD,
  output logic             T0_LOAD,
  output logic      [7:0]  T1_RELOAD,
  output logic             T1_LOAD,
  output logic             T0_RUN,
  output logic             T1_RUN,
  // interrupt enables
  output logic             MASTER_IRQ_FLAG,
  output logic      [3:0]  IRQ_EN_UPPER,
  output logic      [3:0]  IRQ_EN_LOWER
);

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  tid_state_t  state_r;
  tid_state_t  state_nxt;
  logic [7:0]  first_r;
  logic        done_r;

  // architectural state owned by this block
  logic        dec_en_r;
  logic        master_r;
  logic [3:0]  upper_r;
  logic [3:0]  lower_r;
  logic        zero_r;
  logic        run0_r;
  logic        run1_r;
  logic [7:0]  reload0_r;
  logic [7:0]  reload1_r;
  logic        load0_r;
  logic        load1_r;
  tid_cpu_wr_t wr_r;
  tid_cpu_wr_t wr_nxt;

  // ---------------------------------------------------------------
  // opcode classification
  // ---------------------------------------------------------------
  tid_op_t     op_one;
  tid_op_t     op_two;
  logic        has_second;
  logic        any_one;

  // in fetch the classifier looks at the incoming byte, later at the held one
  wire [7:0] cls_first = (state_r == TID_ST_FETCH) ? INS_BYTE : first_r;

  tid_opdec u_opdec (
    .first_byte  (cls_first),
    .second_byte (INS_BYTE),
    .op_one      (op_one),
    .op_two      (op_two),
    .has_second  (has_second)
  );

  assign any_one = (op_one != TID_OP_NONE);

  // handshake: a byte is only wanted in fetch or second-byte states
  wire in_fetch  = (state_r == TID_ST_FETCH);
  wire in_second = (state_r == TID_ST_SECOND);
  wire in_exec   = (state_r == TID_ST_EXEC);
  wire take      = INS_VALID && INS_READY;

  assign INS_READY = dec_en_r && (in_fetch || in_second);

  // the op that commits on this edge, if any
  // one-byte forms commit at the end of their second cycle
  wire     exec_two = in_second && take;
  wire     exec_one = in_exec;

  tid_op_t op_now;
  assign op_now = exec_two ? op_two :
                  exec_one ? op_one :
                  TID_OP_NONE;

  // done follows every recognised op, never a dropped byte
  wire commit = (op_now != TID_OP_NONE);

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TID_ST_FETCH: begin
        if (take && any_one) begin
          state_nxt = TID_ST_EXEC;
        end else if (take && has_second) begin
          state_nxt = TID_ST_SECOND;
        end
      end
      TID_ST_SECOND: begin
        if (take) begin
          state_nxt = TID_ST_FETCH;
        end
      end
      TID_ST_EXEC: begin
        // second machine cycle of a one-byte op; ready is low here
        state_nxt = TID_ST_FETCH;
      end
      default: state_nxt = TID_ST_FETCH;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_r <= TID_ST_FETCH;
      first_r <= `TID_BYTE_RST;
    end else begin
      state_r <= state_nxt;
      if (in_fetch && take) begin
        first_r <= INS_BYTE;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt enable and master flag updates
  // ---------------------------------------------------------------
  // clear ops report zero on the nibble they leave behind
  wire [3:0] imm       = INS_BYTE[3:0];
  wire [3:0] upper_or  = upper_r | imm;
  wire [3:0] lower_or  = lower_r | imm;
  wire [3:0] upper_clr = upper_r & ~imm;
  wire [3:0] lower_clr = lower_r & ~imm;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      master_r <= 1'b0;
      upper_r  <= `TID_NIB_RST;
      lower_r  <= `TID_NIB_RST;
      zero_r   <= 1'b0;
    end else begin
      if (op_now == TID_OP_MSTR_ON)  master_r <= 1'b1;
      if (op_now == TID_OP_MSTR_OFF) master_r <= 1'b0;
      if (op_now == TID_OP_UP_OR)    upper_r  <= upper_or;
      if (op_now == TID_OP_LO_OR)    lower_r  <= lower_or;
      if (op_now == TID_OP_UP_CLR) begin
        upper_r <= upper_clr;
        zero_r  <= (upper_clr == `TID_NIB_RST);
      end
      if (op_now == TID_OP_LO_CLR) begin
        lower_r <= lower_clr;
        zero_r  <= (lower_clr == `TID_NIB_RST);
      end
    end
  end

  // ---------------------------------------------------------------
  // timer run control and reload registers
  // ---------------------------------------------------------------
  // operands are taken on the commit edge, so the core must hold them
  wire [7:0] reload0_val = {CPU_IN.mem_nib, CPU_IN.acc};
  wire [7:0] reload1_val = {CPU_IN.ext, CPU_IN.acc};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      run0_r    <= 1'b0;
      run1_r    <= 1'b0;
      reload0_r <= `TID_BYTE_RST;
      reload1_r <= `TID_BYTE_RST;
      load0_r   <= 1'b0;
      load1_r   <= 1'b0;
    end else begin
      if (op_now == TID_OP_RUN_T0)  run0_r <= 1'b1;
      if (op_now == TID_OP_RUN_T1)  run1_r <= 1'b1;
      if (op_now == TID_OP_HALT_T0) run0_r <= 1'b0;
      if (op_now == TID_OP_HALT_T1) run1_r <= 1'b0;
      load0_r <= (op_now == TID_OP_WR_T0);
      load1_r <= (op_now == TID_OP_WR_T1);
      if (op_now == TID_OP_WR_T0) reload0_r <= reload0_val;
      if (op_now == TID_OP_WR_T1) reload1_r <= reload1_val;
    end
  end

  // ---------------------------------------------------------------
  // write-backs to the core, one cycle after commit
  // ---------------------------------------------------------------
  // strobes and data share one flop stage, so data never leads a strobe
  always_comb begin
    wr_nxt = '0;
    unique case (op_now)
      TID_OP_RD_T0: begin
        wr_nxt.mem_we = 1'b1;
        wr_nxt.mem_d  = T0_COUNT[7:4];
        wr_nxt.acc_we = 1'b1;
        wr_nxt.acc_d  = T0_COUNT[3:0];
      end
      TID_OP_RD_T1: begin
        wr_nxt.ext_we = 1'b1;
        wr_nxt.ext_d  = T1_COUNT[7:4];
        wr_nxt.acc_we = 1'b1;
        wr_nxt.acc_d  = T1_COUNT[3:0];
      end
      TID_OP_UP_CLR: begin
        wr_nxt.zf_we = 1'b1;
        wr_nxt.zf_d  = (upper_clr == `TID_NIB_RST);
      end
      TID_OP_LO_CLR: begin
        wr_nxt.zf_we = 1'b1;
        wr_nxt.zf_d  = (lower_clr == `TID_NIB_RST);
      end
      default: wr_nxt = '0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      wr_r   <= '0;
      done_r <= 1'b0;
    end else begin
      wr_r   <= wr_nxt;
      done_r <= commit;
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave: always ready, always okay, no wait states
  // ---------------------------------------------------------------
  tid_aphase_t ap_r;
  logic [31:0] rdata_r;

  // address phase is accepted only when the previous transfer has ended
  // hsize is not decoded: every register is one aligned word
  wire       ap_take = HSEL && HTRANS[1] && HREADY;
  wire [7:0] ap_ofs  = {HADDR[`TID_ADDR_W-1:2], 2'b00};

  wire hit_ctrl   = (ap_ofs == `TID_CTRL_OFS);
  wire hit_stat   = (ap_ofs == `TID_STAT_OFS);
  wire hit_reload = (ap_ofs == `TID_RELOAD_OFS);

  // status view of the block's own state
  wire [31:0] stat_word = {20'h0_0000,
                           lower_r,
                           upper_r,
                           zero_r,
                           run1_r,
                           run0_r,
                           master_r};

  wire [31:0] reload_word = {16'h0000, reload1_r, reload0_r};
  wire [31:0] ctrl_word   = {31'h0000_0000, dec_en_r};

  // read data is picked in the address phase so hrdata leaves a flop
  wire [31:0] rd_sel = hit_ctrl   ? ctrl_word   :
                       hit_stat   ? stat_word   :
                       hit_reload ? reload_word :
                       32'h0000_0000;

  wire wr_ctrl = ap_r.vld && ap_r.wr && (ap_r.ofs == `TID_CTRL_OFS);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      ap_r    <= '0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ap_r.vld <= ap_take;
      ap_r.wr  <= HWRITE;
      ap_r.ofs <= ap_ofs;
      if (ap_take && !HWRITE) begin
        rdata_r <= rd_sel;
      end
    end
  end

  // pausing the decoder only holds off new bytes; a one-byte op in exec finishes, a taken prefix waits for its second byte
  // only the enable bit of the ctrl reset word lives in a flop
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      dec_en_r <= 1'(`TID_CTRL_RST);
    end else if (wr_ctrl) begin
      dec_en_r <= HWDATA[`TID_CTRL_EN_BIT];
    end
  end

  // no wait states: every register answers in the next cycle
  assign HRDATA    = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign INS_DONE        = done_r;
  assign CPU_WR          = wr_r;
  assign T0_RELOAD       = reload0_r;
  assign T1_RELOAD       = reload1_r;
  assign T0_LOAD         = load0_r;
  assign T1_LOAD         = load1_r;
  assign T0_RUN          = run0_r;
  assign T1_RUN          = run1_r;
  assign MASTER_IRQ_FLAG = master_r;
  assign IRQ_EN_UPPER    = upper_r;
  assign IRQ_EN_LOWER    = lower_r;

endmodule
`default_nettype wire

// File: pkg/tid_map.svh
// offsets, opcodes, field positions and reset values of the timer/irq decoder
`ifndef TID_MAP_SVH
`define TID_MAP_SVH

// register byte offsets on the ahb-lite port
`define TID_CTRL_OFS     8'h00
`define TID_STAT_OFS     8'h04
`define TID_RELOAD_OFS   8'h08
`define TID_ADDR_W       8

// ctrl register fields and reset value
`define TID_CTRL_EN_BIT  0
`define TID_CTRL_RST     32'h0000_0001

// status register field positions
`define TID_ST_MASTER    0
`define TID_ST_RUN0      1
`define TID_ST_RUN1      2
`define TID_ST_ZERO      3
`define TID_ST_UPPER_LO  4
`define TID_ST_LOWER_LO  8

// reload register field positions
`define TID_RL_T0_LO     0
`define TID_RL_T1_LO     8

// first opcode bytes
`define TID_OP_WR_T0     8'hCA
`define TID_OP_RD_T0     8'hCB
`define TID_PFX_IRQ_LO   8'hC4
`define TID_PFX_IRQ_UP   8'hC5
`define TID_PFX_CLR_LO   8'hC8
`define TID_PFX_CLR_UP   8'hC9
`define TID_PFX_TMR_A    8'hCE
`define TID_PFX_TMR_B    8'hCF

// second opcode bytes
`define TID_SB_WR_T1     8'hF4
`define TID_SB_RD_T1     8'hF5
`define TID_SB_T0        8'hF6
`define TID_SB_T1        8'hF7
`define TID_SB_IRQ_HI    4'hD

// reset values of the nibbles and bytes
`define TID_NIB_RST      4'h0
`define TID_BYTE_RST     8'h00

`endif

// File: pkg/tid_pkg.sv
// types shared by the timer/irq instruction decoder
package tid_pkg;

  typedef enum logic [3:0] {
    TID_OP_NONE,
    TID_OP_WR_T0,
    TID_OP_WR_T1,
    TID_OP_RD_T0,
    TID_OP_RD_T1,
    TID_OP_RUN_T0,
    TID_OP_RUN_T1,
    TID_OP_HALT_T0,
    TID_OP_HALT_T1,
    TID_OP_MSTR_ON,
    TID_OP_MSTR_OFF,
    TID_OP_UP_OR,
    TID_OP_LO_OR,
    TID_OP_UP_CLR,
    TID_OP_LO_CLR
  } tid_op_t;

  typedef enum logic [2:0] {
    TID_ST_FETCH  = 3'b001,
    TID_ST_SECOND = 3'b010,
    TID_ST_EXEC   = 3'b100
  } tid_state_t;

  // core operands the decoder reads
  typedef struct packed {
    logic [3:0] mem_nib;
    logic [3:0] ext;
    logic [3:0] acc;
  } tid_cpu_in_t;

  // core write-backs, each strobe with its data
  typedef struct packed {
    logic       mem_we;
    logic [3:0] mem_d;
    logic       ext_we;
    logic [3:0] ext_d;
    logic       acc_we;
    logic [3:0] acc_d;
    logic       zf_we;
    logic       zf_d;
  } tid_cpu_wr_t;

  // ahb-lite address phase as captured by the slave
  typedef struct packed {
    logic                 vld;
    logic                 wr;
    logic [7:0]           ofs;
  } tid_aphase_t;

endpackage

// File: core/tid_opdec.sv
// opcode classifier for the timer and interrupt control group
`timescale 1ns/1ns
`default_nettype none
`include "tid_map.svh"

module tid_opdec
  import tid_pkg::*;
(
  // opcode bytes
  input  wire logic [7:0] first_byte,
  input  wire logic [7:0] second_byte,
  // classification
  output tid_op_t         op_one,
  output tid_op_t         op_two,
  output logic            has_second
);

  wire [3:0] sb_hi = second_byte[7:4];
  wire [3:0] imm   = second_byte[3:0];
  wire       irq_b = (sb_hi == `TID_SB_IRQ_HI);
  wire       imm_z = (imm == `TID_NIB_RST);

  // one-byte forms
  assign op_one = (first_byte == `TID_OP_WR_T0) ? TID_OP_WR_T0 :
                  (first_byte == `TID_OP_RD_T0) ? TID_OP_RD_T0 :
                  TID_OP_NONE;

  assign has_second = (first_byte == `TID_PFX_IRQ_LO) ||
                      (first_byte == `TID_PFX_IRQ_UP) ||
                      (first_byte == `TID_PFX_CLR_LO) ||
                      (first_byte == `TID_PFX_CLR_UP) ||
                      (first_byte == `TID_PFX_TMR_A)  ||
                      (first_byte == `TID_PFX_TMR_B);

  // two-byte forms; a zero immediate with an upper-nibble prefix (C5 or C9) is the master flag op
  always_comb begin
    op_two = TID_OP_NONE;
    unique case (first_byte)
      `TID_PFX_TMR_A: begin
        if (second_byte == `TID_SB_WR_T1) op_two = TID_OP_WR_T1;
        if (second_byte == `TID_SB_T0)    op_two = TID_OP_RUN_T0;
        if (second_byte == `TID_SB_T1)    op_two = TID_OP_RUN_T1;
      end
      `TID_PFX_TMR_B: begin
        if (second_byte == `TID_SB_RD_T1) op_two = TID_OP_RD_T1;
        if (second_byte == `TID_SB_T0)    op_two = TID_OP_HALT_T0;
        if (second_byte == `TID_SB_T1)    op_two = TID_OP_HALT_T1;
      end
      `TID_PFX_IRQ_UP: begin
        if (irq_b) op_two = imm_z ? TID_OP_MSTR_ON : TID_OP_UP_OR;
      end
      `TID_PFX_CLR_UP: begin
        if (irq_b) op_two = imm_z ? TID_OP_MSTR_OFF : TID_OP_UP_CLR;
      end
      `TID_PFX_IRQ_LO: begin
        if (irq_b) op_two = TID_OP_LO_OR;
      end
      `TID_PFX_CLR_LO: begin
        if (irq_b) op_two = TID_OP_LO_CLR;
      end
      default: op_two = TID_OP_NONE;
    endcase
  end

endmodule
`default_nettype wire

// File: tb/tid_core_checker.sv
// concurrent checks on the decoder's instruction, timer and enable ports
`timescale 1ns/1ns
`default_nettype none
module tid_core_checker
  import tid_pkg::*;
(
  // clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // instruction stream
  input wire logic        INS_VALID,
  input wire logic [7:0]  INS_BYTE,
  input wire logic        INS_READY,
  input wire logic        INS_DONE,
  // core side
  input wire tid_cpu_in_t CPU_IN,
  input wire tid_cpu_wr_t CPU_WR,
  // timers and enables
  input wire logic [7:0]  T0_COUNT,
  input wire logic [7:0]  T1_COUNT,
  input wire logic [7:0]  T0_RELOAD,
  input wire logic        T0_LOAD,
  input wire logic [7:0]  T1_RELOAD,
  input wire logic        T1_LOAD,
  input wire logic        T0_RUN,
  input wire logic        T1_RUN,
  input wire logic        MASTER_IRQ_FLAG,
  input wire logic [3:0]  IRQ_EN_UPPER,
  input wire logic [3:0]  IRQ_EN_LOWER
);
  logic first;
  logic sec_r;
  logic clr_up_r;
  assign first = INS_VALID && INS_READY && !sec_r;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // a byte taken while a prefix waits is a second byte, never an opcode
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sec_r <= 1'b0;
      clr_up_r <= 1'b0;
    end else if (INS_VALID && INS_READY) begin
      sec_r <= !sec_r && (INS_BYTE inside {8'hC4, 8'hC5, 8'hC8, 8'hC9, 8'hCE, 8'hCF});
      if (!sec_r && (INS_BYTE == 8'hC8 || INS_BYTE == 8'hC9))
        clr_up_r <= INS_BYTE[0];
    end
  end
  AST_WR_T0: assert property (first && INS_BYTE == 8'hCA |=> !INS_READY ##1 INS_DONE && T0_LOAD)
    else $error("timer 0 reload write late");
  AST_LD_T0: assert property (T0_LOAD |-> T0_RELOAD == {$past(CPU_IN.mem_nib), $past(CPU_IN.acc)})
    else $error("timer 0 reload value wrong");
  AST_LD_T1: assert property (T1_LOAD |-> INS_DONE && T1_RELOAD == {$past(CPU_IN.ext), $past(CPU_IN.acc)})
    else $error("timer 1 reload value wrong");
  AST_RD_T0: assert property (first && INS_BYTE == 8'hCB |-> ##2 INS_DONE && CPU_WR.mem_we && CPU_WR.acc_we
    && {CPU_WR.mem_d, CPU_WR.acc_d} == $past(T0_COUNT)) else $error("timer 0 read wrong");
  AST_RD_T1: assert property (CPU_WR.ext_we |-> INS_DONE && CPU_WR.acc_we && !CPU_WR.mem_we
    && {CPU_WR.ext_d, CPU_WR.acc_d} == $past(T1_COUNT)) else $error("timer 1 read wrong");
  AST_RUN_T0: assert property (!$past(SYS_RST) && $changed(T0_RUN) |-> INS_DONE && !T0_LOAD)
    else $error("timer 0 run changed without instruction");
  AST_RUN_T1: assert property (!$past(SYS_RST) && $changed(T1_RUN) |-> INS_DONE && !T1_LOAD)
    else $error("timer 1 run changed without instruction");
  AST_MASTER: assert property (!$past(SYS_RST) && $changed(MASTER_IRQ_FLAG) |-> INS_DONE && !CPU_WR.zf_we)
    else $error("master flag changed wrongly");
  AST_UP_SET: assert property (|(IRQ_EN_UPPER & ~$past(IRQ_EN_UPPER)) |-> INS_DONE && !CPU_WR.zf_we)
    else $error("upper bits set wrongly");
  AST_UP_CLR: assert property (!$past(SYS_RST) && |(~IRQ_EN_UPPER & $past(IRQ_EN_UPPER)) |-> CPU_WR.zf_we)
    else $error("upper bits cleared wrongly");
  AST_LO_SET: assert property (|(IRQ_EN_LOWER & ~$past(IRQ_EN_LOWER)) |-> INS_DONE && !CPU_WR.zf_we)
    else $error("lower bits set wrongly");
  AST_LO_CLR: assert property (!$past(SYS_RST) && |(~IRQ_EN_LOWER & $past(IRQ_EN_LOWER)) |-> CPU_WR.zf_we)
    else $error("lower bits cleared wrongly");
  AST_ZERO: assert property (CPU_WR.zf_we |-> INS_DONE &&
    CPU_WR.zf_d == (clr_up_r ? IRQ_EN_UPPER == 4'h0 : IRQ_EN_LOWER == 4'h0)) else $error("zero flag wrong");
endmodule
`default_nettype wire

// File: tb/test_timer_interrupt_instr_decode.sv
// self-checking bench for the timer and interrupt instruction decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((e) !== (g)) begin n_fail++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_timer_interrupt_instr_decode
  import tid_pkg::*;
;
  logic        CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        HSEL = 1'b0;
  logic        HWRITE = 1'b0;
  logic        INS_VALID = 1'b0;
  logic [1:0]  HTRANS = 2'b00;
  logic [31:0] HADDR = 32'h0000_0000;
  logic [31:0] HWDATA = 32'h0000_0000;
  logic [31:0] HRDATA, rd;
  logic        HREADYOUT, HRESP, INS_READY, INS_DONE, T0_LOAD, T1_LOAD, T0_RUN, T1_RUN, MASTER_IRQ_FLAG;
  logic [7:0]  INS_BYTE = 8'h00, T0_COUNT = 8'h00, T1_COUNT = 8'h00, lf = 8'h3C;
  logic [7:0]  T0_RELOAD, T1_RELOAD, r0 = 8'h00, r1 = 8'h00;
  logic [3:0]  IRQ_EN_UPPER, IRQ_EN_LOWER, up = 4'h0, lo = 4'h0;
  logic        run0 = 1'b0, run1 = 1'b0, ms = 1'b0, zf = 1'b0;
  tid_cpu_in_t CPU_IN = 12'h000;
  tid_cpu_wr_t CPU_WR;
  logic [45:0] q[$];
  logic [45:0] ex;
  int          n_fail = 0, total_checks = 0;

  always #2 CLK = ~CLK;

  tid_core tid_core_i (.CLK, .SYS_RST, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HREADY(HREADYOUT), .HWDATA,
    .HRDATA, .HREADYOUT, .HRESP, .INS_VALID, .INS_BYTE, .INS_READY, .INS_DONE, .CPU_IN, .CPU_WR, .T0_COUNT,
    .T1_COUNT, .T0_RELOAD, .T0_LOAD, .T1_RELOAD, .T1_LOAD, .T0_RUN, .T1_RUN, .MASTER_IRQ_FLAG, .IRQ_EN_UPPER,
    .IRQ_EN_LOWER);

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // write-back data only counts while its strobe is up
  function automatic logic [45:0] snap();
    return {CPU_WR.mem_we, CPU_WR.mem_d & {4{CPU_WR.mem_we}}, CPU_WR.ext_we, CPU_WR.ext_d & {4{CPU_WR.ext_we}},
      CPU_WR.acc_we, CPU_WR.acc_d & {4{CPU_WR.acc_we}}, CPU_WR.zf_we, CPU_WR.zf_d & CPU_WR.zf_we, T0_LOAD, T1_LOAD,
      T0_RELOAD, T1_RELOAD, T0_RUN, T1_RUN, MASTER_IRQ_FLAG, IRQ_EN_UPPER, IRQ_EN_LOWER};
  endfunction

  always @(negedge CLK) begin
    if (INS_DONE === 1'b1) begin
      if (q.size() == 0)
        `CHK("stray done", 1'b0, INS_DONE)
      else begin
        ex = q.pop_front();
        `CHK("done snapshot", ex, snap())
      end
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= {24'h00_0000, a};
    HWRITE <= w;
    @(negedge CLK);
    while (HREADYOUT !== 1'b1) @(negedge CLK);
    @(posedge CLK);
    HSEL <= 1'b0;
    HTRANS <= 2'b00;
    HWDATA <= d;
    @(negedge CLK);
    while (HREADYOUT !== 1'b1) @(negedge CLK);
    rd = HRDATA;
    @(posedge CLK);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0000_0000);
    `CHK("read data", e, rd)
    `CHK("okay response", 1'b0, HRESP)
  endtask

  task automatic chk_state();
    rdchk(8'h04, {20'h0_0000, lo, up, zf, run1, run0, ms});
    rdchk(8'h08, {16'h0000, r1, r0});
  endtask

  task automatic put(input logic [7:0] b);
    INS_VALID <= 1'b1;
    INS_BYTE <= b;
    @(negedge CLK);
    while (INS_READY !== 1'b1) @(negedge CLK);
    @(posedge CLK);
  endtask

  task automatic ins(input logic [7:0] b1, input logic [7:0] b2);
    tid_cpu_wr_t w;
    tid_cpu_in_t c;
    logic [7:0]  t0, t1;
    logic        ok, l0, l1;
    w = '0;
    ok = 1'b1;
    l0 = 1'b0;
    l1 = 1'b0;
    lf = lfsr(lf);
    t0 = lf;
    lf = lfsr(lf);
    t1 = lf;
    lf = lfsr(lf);
    c = {lf, t0[3:0] ^ t1[7:4]};
    CPU_IN <= c;
    T0_COUNT <= t0;
    T1_COUNT <= t1;
    if (b1 == 8'hCA) begin
      r0 = {c.mem_nib, c.acc};
      l0 = 1'b1;
    end else if (b1 == 8'hCB)
      w = {1'b1, t0[7:4], 5'h00, 1'b1, t0[3:0], 2'b00};
    else if ({b1, b2} == 16'hCEF4) begin
      r1 = {c.ext, c.acc};
      l1 = 1'b1;
    end else if ({b1, b2} == 16'hCFF5)
      w = {5'h00, 1'b1, t1[7:4], 1'b1, t1[3:0], 2'b00};
    else if (b1[7:1] == 7'h67 && b2[7:1] == 7'h7B) begin
      if (b2[0])
        run1 = !b1[0];
      else
        run0 = !b1[0];
    end else if ({b1, b2} == 16'hC5D0)
      ms = 1'b1;
    else if ({b1, b2} == 16'hC9D0)
      ms = 1'b0;
    else if (b2[7:4] != 4'hD)
      ok = 1'b0;
    else if (b1 == 8'hC5)
      up = up | b2[3:0];
    else if (b1 == 8'hC4)
      lo = lo | b2[3:0];
    else if (b1 == 8'hC9 || b1 == 8'hC8) begin
      if (b1[0])
        up = up & ~b2[3:0];
      else
        lo = lo & ~b2[3:0];
      zf = b1[0] ? up == 4'h0 : lo == 4'h0;
      w = {15'h0000, 1'b1, zf};
    end else
      ok = 1'b0;
    if (ok)
      q.push_back({w, l0, l1, r0, r1, run0, run1, ms, up, lo});
    put(b1);
    if (b1 != 8'hCA && b1 != 8'hCB)
      put(b2);
    INS_VALID <= 1'b0;
    repeat (10) if (q.size() != 0) @(posedge CLK);
    // a few more edges so that a stray done pulse is caught
    repeat (3) @(posedge CLK);
    `CHK("pending", 0, q.size())
    chk_state();
  endtask

  initial begin
    repeat (5) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(posedge CLK);
    rdchk(8'h00, 32'h0000_0001);
    chk_state();
    rdchk(8'h0C, 32'h0000_0000);
    ins(8'hCA, 8'h00);
    ins(8'hCE, 8'hF4);
    ins(8'hCB, 8'h00);
    ins(8'hCF, 8'hF5);
    ins(8'hCE, 8'hF6);
    ins(8'hCE, 8'hF7);
    ins(8'hCF, 8'hF6);
    ins(8'hCF, 8'hF7);
    ins(8'hC5, 8'hD0);
    ins(8'hC9, 8'hD0);
    ins(8'hC8, 8'hD0);
    ins(8'h00, 8'h00);
    ins(8'hCE, 8'h00);
    for (int k = 0; k < 8; k++) begin
      lf = lfsr(lf);
      ins(8'hC5, {4'hD, lf[3:0]});
      ins(8'hC4, {4'hD, lf[7:4]});
      lf = lfsr(lf);
      ins(8'hC9, {4'hD, lf[3:0]});
      ins(8'hC8, {4'hD, lf[7:4]});
    end
    ins(8'hC9, 8'hDF);
    ahb(1'b1, 8'h00, 32'h0000_0000);
    @(negedge CLK);
    `CHK("ready when off", 1'b0, INS_READY)
    @(posedge CLK);
    ahb(1'b1, 8'h04, 32'hFFFF_FFFF);
    ahb(1'b1, 8'h08, 32'hFFFF_FFFF);
    rdchk(8'h00, 32'h0000_0000);
    ahb(1'b1, 8'h00, 32'h0000_0001);
    chk_state();
    ins(8'hCA, 8'h00);
    print_verdict();
  end

  initial begin
    #80000;
    n_fail++;
    print_verdict();
  end
endmodule

bind tid_core tid_core_checker tid_core_checker_i (.CLK, .SYS_RST, .INS_VALID, .INS_BYTE, .INS_READY, .INS_DONE,
  .CPU_IN, .CPU_WR, .T0_COUNT, .T1_COUNT, .T0_RELOAD, .T0_LOAD, .T1_RELOAD, .T1_LOAD, .T0_RUN, .T1_RUN,
  .MASTER_IRQ_FLAG, .IRQ_EN_UPPER, .IRQ_EN_LOWER);
`default_nettype wire
